// *** common/swdt_defs.svh ***
/*
  Constants for the system watchdog: field widths, reset values and tick timing.
  Assumes a 100 MHz system clock.
*/
`ifndef SWDT_DEFS_SVH
`define SWDT_DEFS_SVH

`define SWDT_CLK_PERIOD_NS   40'h000000000A
`define SWDT_UNIT_SEC_NS     40'h003B9ACA00
`define SWDT_UNIT_MIN_NS     40'h0DF8475800
`define SWDT_CYC_SEC         (`SWDT_UNIT_SEC_NS / `SWDT_CLK_PERIOD_NS)
`define SWDT_CYC_MIN         (`SWDT_UNIT_MIN_NS / `SWDT_CLK_PERIOD_NS)
`define SWDT_CNT_W           8
`define SWDT_CNT_RST         8'h00
`define SWDT_RST_PULSE_CYC   16
`define SWDT_PRE_W           40

`endif

// *** common/swdt_pkg.sv ***
/*
  Types for the system watchdog.
  Assumes the constants header is compiled alongside.
*/
`default_nettype none
package swdt_pkg;
  typedef enum logic [1:0] {
    SWDT_IDLE  = 2'b00,
    SWDT_RUN   = 2'b01,
    SWDT_FIRE  = 2'b10
  } swdt_state_t;

  typedef enum logic {
    SWDT_ACT_RESET = 1'b0,
    SWDT_ACT_NMI   = 1'b1
  } swdt_action_t;
endpackage
`default_nettype wire

// *** common/swdt_tick_if.sv ***
/*
  Carrier between the watchdog core and its unit-tick generator.
  Assumes a single clock domain.
*/
`timescale 1ns/100ps
`default_nettype none
interface swdt_tick_if;
  logic restart;
  logic tick;
  modport gen  (input restart, output tick);
  modport core (output restart, input tick);
endinterface
`default_nettype wire

// *** hw/swdt_tick.sv ***
/*
  Unit-tick generator: one pulse per selected time unit, realigned on restart.
  Assumes the unit select is already synchronous to clk_i.
*/
`timescale 1ns/100ps
`default_nettype none
`include "swdt_defs.svh"
module swdt_tick #(
  parameter logic [`SWDT_PRE_W-1:0] SEC_CYC = `SWDT_PRE_W'(`SWDT_CYC_SEC),
  parameter logic [`SWDT_PRE_W-1:0] MIN_CYC = `SWDT_PRE_W'(`SWDT_CYC_MIN)
) (
  // Clock and reset
  input  wire logic   clk_i,
  input  wire logic   rst_n_i,
  // Unit select, 0 seconds, 1 minutes
  input  wire logic   unit_min_i,
  // Core side
  swdt_tick_if.gen    tk
);
  logic [`SWDT_PRE_W-1:0] pre_q;
  logic [`SWDT_PRE_W-1:0] pre_d;
  logic [`SWDT_PRE_W-1:0] last;
  logic                   wrap;

  assign last  = (unit_min_i ? MIN_CYC : SEC_CYC) - `SWDT_PRE_W'(1);
  assign wrap  = (pre_q >= last);
  assign pre_d = (tk.restart || wrap) ? '0 : pre_q + `SWDT_PRE_W'(1);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_d;
    end
  end

  assign tk.tick = wrap && !tk.restart;
endmodule
`default_nettype wire

// *** hw/swdt_top.sv ***
/*
  System watchdog: loads an 8-bit time-out, counts it down once per selected
  unit, and on expiry raises a cold-boot reset pulse or an NMI.
  Assumes loads come from same-clock logic; unit and action selects are
  static configuration pins and are synchronised here.
*/
// Behaviour
// - Loading a nonzero time-out starts the countdown from that value.
// - When the count reaches zero the configured recovery action fires.
// - Every load outside the cold-boot reset pulse restarts the countdown from the newly written value.
// - Loading zero disables the watchdog until a nonzero value is loaded.
// - Expiry raises either a cold-boot reset pulse or an NMI, as selected.
// - One count lasts one unit chosen by a separate unit-select setting.
`timescale 1ns/100ps
`default_nettype none
`include "swdt_defs.svh"
module swdt_top #(
  parameter logic [`SWDT_PRE_W-1:0] SEC_CYC   = `SWDT_PRE_W'(`SWDT_CYC_SEC),
  parameter logic [`SWDT_PRE_W-1:0] MIN_CYC   = `SWDT_PRE_W'(`SWDT_CYC_MIN),
  parameter int unsigned            PULSE_CYC = `SWDT_RST_PULSE_CYC
) (
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_n_i,
  // Time-out load from firmware service
  input  wire logic                  load_i,
  input  wire logic [`SWDT_CNT_W-1:0] load_val_i,
  // Configuration pins
  input  wire logic                  unit_min_i,
  input  wire logic                  act_nmi_i,
  // Recovery and status
  output logic                       cold_reset_o,
  output logic                       nmi_o,
  output logic                       enabled_o,
  output logic [`SWDT_CNT_W-1:0]     count_o
);
  swdt_tick_if tk ();

  logic [2:0] unit_sync_q;
  logic [2:0] act_sync_q;
  logic       unit_q;
  logic       act_q;

  swdt_pkg::swdt_state_t  state_q;
  swdt_pkg::swdt_state_t  state_d;
  logic [`SWDT_CNT_W-1:0] cnt_q;
  logic [`SWDT_CNT_W-1:0] cnt_d;
  logic [7:0]             pulse_q;
  logic [7:0]             pulse_d;
  logic                   rst_q;
  logic                   nmi_q;
  logic                   en_q;
  logic                   expire;
  logic                   pulse_end;
  logic                   act_is_nmi;

  // Config pins: three flops, take a change once stages two and three agree
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      unit_sync_q <= 3'h0;
      act_sync_q  <= 3'h0;
      unit_q      <= 1'b0;
      act_q       <= 1'b0;
    end else begin
      unit_sync_q <= {unit_sync_q[1:0], unit_min_i};
      act_sync_q  <= {act_sync_q[1:0], act_nmi_i};
      if (unit_sync_q[2] == unit_sync_q[1]) begin
        unit_q <= unit_sync_q[2];
      end
      if (act_sync_q[2] == act_sync_q[1]) begin
        act_q <= act_sync_q[2];
      end
    end
  end

  assign act_is_nmi = (swdt_pkg::swdt_action_t'(act_q) == swdt_pkg::SWDT_ACT_NMI);

  swdt_tick #(
    .SEC_CYC (SEC_CYC),
    .MIN_CYC (MIN_CYC)
  ) u_tick (
    .clk_i      (clk_i),
    .rst_n_i    (rst_n_i),
    .unit_min_i (unit_q),
    .tk         (tk.gen)
  );

  assign tk.restart = load_i;
  assign expire     = (state_q == swdt_pkg::SWDT_RUN) && tk.tick &&
                      (cnt_q == `SWDT_CNT_W'(1)) && !load_i;
  assign pulse_end  = (pulse_q == 8'h01);

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    pulse_d = pulse_q;
    case (state_q)
      swdt_pkg::SWDT_IDLE: begin
        if (load_i && load_val_i != '0) begin
          state_d = swdt_pkg::SWDT_RUN;
          cnt_d   = load_val_i;
        end
      end
      swdt_pkg::SWDT_RUN: begin
        if (load_i) begin
          cnt_d   = load_val_i;
          if (load_val_i == '0) begin
            state_d = swdt_pkg::SWDT_IDLE;
          end
        end else if (expire) begin
          cnt_d   = '0;
          state_d = swdt_pkg::SWDT_FIRE;
          pulse_d = 8'(PULSE_CYC);
        end else if (tk.tick) begin
          cnt_d = cnt_q - `SWDT_CNT_W'(1);
        end
      end
      swdt_pkg::SWDT_FIRE: begin
        if (act_is_nmi) begin
          // NMI stays raised until software reloads or disables
          if (load_i) begin
            cnt_d   = load_val_i;
            state_d = (load_val_i == '0) ? swdt_pkg::SWDT_IDLE : swdt_pkg::SWDT_RUN;
          end
        end else begin
          pulse_d = pulse_q - 8'h01;
          if (pulse_end) begin
            state_d = swdt_pkg::SWDT_IDLE;
          end
        end
      end
      default: begin
        state_d = swdt_pkg::SWDT_IDLE;
        cnt_d   = '0;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= swdt_pkg::SWDT_IDLE;
      cnt_q   <= `SWDT_CNT_RST;
      pulse_q <= 8'h00;
      rst_q   <= 1'b0;
      nmi_q   <= 1'b0;
      en_q    <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      pulse_q <= pulse_d;
      rst_q   <= (state_d == swdt_pkg::SWDT_FIRE) && !act_is_nmi;
      nmi_q   <= (state_d == swdt_pkg::SWDT_FIRE) && act_is_nmi;
      en_q    <= (state_d == swdt_pkg::SWDT_RUN);
    end
  end

  assign cold_reset_o = rst_q;
  assign nmi_o        = nmi_q;
  assign enabled_o    = en_q;
  assign count_o      = cnt_q;

  expiry_fires_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    expire |=> (state_q == swdt_pkg::SWDT_FIRE) ##1 (cold_reset_o || nmi_o))
    else $error("expiry did not fire recovery");

  load_nonzero_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (load_i && load_val_i != '0) |=> (enabled_o && count_o == $past(load_val_i)))
    else $error("nonzero load did not start countdown");

  load_zero_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (load_i && load_val_i == '0) |=> (!enabled_o && count_o == '0) ##1 !cold_reset_o)
    else $error("zero load did not disable");

  reload_restart_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state_q == swdt_pkg::SWDT_RUN && load_i) |=> count_o == $past(load_val_i))
    else $error("reload did not restart count");

  tick_dec_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (enabled_o && tk.tick && !load_i && count_o > 8'h01) |=> count_o == $past(count_o) - 8'h01)
    else $error("count did not decrement on tick");

  hold_notick_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (enabled_o && !tk.tick && !load_i) |=> $stable(count_o))
    else $error("count moved without unit tick");

  action_excl_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !(cold_reset_o && nmi_o))
    else $error("both recovery actions raised");

  idle_quiet_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state_q == swdt_pkg::SWDT_IDLE) |-> (count_o == '0 && !nmi_o))
    else $error("idle state not clean");
endmodule
`default_nettype wire

// *** testbench/tb_swdt_top.sv ***
/*
  Self-checking bench for the system watchdog top.
  Assumes shortened unit and pulse parameters; the bench drives every pin itself.
*/
`timescale 1ns/100ps
`default_nettype none
`include "swdt_defs.svh"
module tb_swdt_top;
  localparam int SEC = 10;
  localparam int MIN = 20;
  localparam int PW  = 4;
  logic                   clk_i;
  logic                   rst_n_i;
  logic                   load_i;
  logic [`SWDT_CNT_W-1:0] load_val_i;
  logic                   unit_min_i;
  logic                   act_nmi_i;
  logic                   cold_reset_o;
  logic                   nmi_o;
  logic                   enabled_o;
  logic [`SWDT_CNT_W-1:0] count_o;
  int                     mismatches = 0;
  int                     n_tests = 0;
  int                     el = 0;
  int                     pw = 0;
  int                     exp_c;
  logic [`SWDT_CNT_W-1:0] exp_v;
  logic                   ld_q = 1'b0;
  logic                   fire_q = 1'b0;
  logic [7:0]             lfsr_q = 8'h28;
  logic [`SWDT_CNT_W-1:0] ldq[$];
  int                     fcyc[$];
  logic                   fnmi[$];

  swdt_top #(
    .SEC_CYC  (`SWDT_PRE_W'(SEC)),
    .MIN_CYC  (`SWDT_PRE_W'(MIN)),
    .PULSE_CYC(PW)
  ) dut (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .load_i      (load_i),
    .load_val_i  (load_val_i),
    .unit_min_i  (unit_min_i),
    .act_nmi_i   (act_nmi_i),
    .cold_reset_o(cold_reset_o),
    .nmi_o       (nmi_o),
    .enabled_o   (enabled_o),
    .count_o     (count_o)
  );

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // One load pulse; a positive fire_cyc notes an expiry that many cycles later
  task automatic load(input logic [7:0] v, input int fire_cyc);
    @(posedge clk_i);
    load_i     <= 1'b1;
    load_val_i <= v;
    ldq.push_back(v);
    if (fire_cyc > 0) begin
      fcyc.push_back(fire_cyc);
      fnmi.push_back(act_nmi_i);
    end
    @(posedge clk_i);
    load_i <= 1'b0;
  endtask

  // Output watcher: load answers, expiry timing and action, pulse width
  always @(posedge clk_i) begin
    ld_q   <= load_i;
    el     <= load_i ? 1 : el + 1;
    fire_q <= cold_reset_o | nmi_o;
    if (ld_q) begin
      exp_v = ldq.pop_front();
      check(count_o, exp_v);
      check(enabled_o, exp_v != 0);
    end
    if ((cold_reset_o | nmi_o) && !fire_q) begin
      if (fcyc.size() == 0) begin
        check(1, 0);
      end else begin
        exp_c = fcyc.pop_front();
        check(el, exp_c + 1);
        check(nmi_o, fnmi.pop_front());
      end
    end
    if (cold_reset_o) begin
      pw <= pw + 1;
    end else if (pw != 0) begin
      check(pw, PW);
      pw <= 0;
    end
  end

  initial begin
    repeat (5000) @(posedge clk_i);
    mismatches++;
    complete_run();
  end

  initial begin
    rst_n_i    = 1'b0;
    load_i     = 1'b0;
    load_val_i = 8'h00;
    unit_min_i = 1'b0;
    act_nmi_i  = 1'b0;
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    check({cold_reset_o, nmi_o, enabled_o, count_o}, 0);
    repeat (5) @(posedge clk_i);
    load(8'h03, 3 * SEC);
    repeat (14) @(posedge clk_i);
    check(count_o, 2);
    repeat (3 * SEC + PW + 10) @(posedge clk_i);
    check(enabled_o, 0);
    $display("test expiry done");
    load(8'h05, 0);
    repeat (3 * SEC) @(posedge clk_i);
    load(8'h05, 5 * SEC);
    repeat (5 * SEC + PW + 10) @(posedge clk_i);
    $display("test refresh done");
    load(8'h04, 0);
    repeat (2 * SEC) @(posedge clk_i);
    load(8'h00, 0);
    repeat (10 * SEC) @(posedge clk_i);
    check(enabled_o, 0);
    $display("test disable done");
    unit_min_i <= 1'b1;
    act_nmi_i  <= 1'b1;
    repeat (6) @(posedge clk_i);
    load(8'h02, 2 * MIN);
    repeat (2 * MIN + 20) @(posedge clk_i);
    check(nmi_o, 1);
    load(8'h01, MIN);
    @(posedge clk_i);
    check(nmi_o, 0);
    repeat (MIN + 2) @(posedge clk_i);
    check(nmi_o, 1);
    load(8'h00, 0);
    @(posedge clk_i);
    check(nmi_o, 0);
    $display("test nmi done");
    unit_min_i <= 1'b0;
    act_nmi_i  <= 1'b0;
    repeat (6) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      lfsr_q = lfsr_next(lfsr_q);
      load_i     <= 1'b1;
      load_val_i <= lfsr_q;
      ldq.push_back(lfsr_q);
      @(posedge clk_i);
    end
    load_i <= 1'b0;
    load(8'h00, 0);
    $display("test back to back done");
    load(8'h02, 0);
    repeat (SEC) @(posedge clk_i);
    rst_n_i <= 1'b0;
    @(posedge clk_i);
    check({cold_reset_o, nmi_o, enabled_o, count_o}, 0);
    rst_n_i <= 1'b1;
    repeat (4 * SEC) @(posedge clk_i);
    check(enabled_o, 0);
    $display("test reset done");
    check(fcyc.size() + ldq.size(), 0);
    complete_run();
  end
endmodule
`default_nettype wire
